// file: core/mac_tx_pkg.sv
// Constants, register map and types for the transmit setup/status block.
// Assumes a 50 MHz system clock and a 32-bit APB register bus.
package mac_tx_pkg;

	// Clock and media timing, figures in ns
	localparam int CLK_NS = 20;
	localparam int SLOT_NS = 51200; // One slot time, 51.2 us
	localparam int HB_NS = 6400; // Heartbeat window, 6.4 us
	// Least time rounds up, longest time rounds down
	localparam int SLOT_CYC = (SLOT_NS + CLK_NS - 1) / CLK_NS;
	localparam int HB_CYC = HB_NS / CLK_NS;
	localparam int TMR_W = 12; // Wide enough for both windows

	// Register indices; byte address is four times the index
	localparam int ADDR_W = 8;
	localparam logic [5:0] IDX_STATUS = 6'h04;
	localparam logic [5:0] IDX_SETUP = 6'h0D;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
	localparam logic [5:0] IDX_IRQ_EN = 6'h11;
	localparam logic [5:0] IDX_IRQ_CLR = 6'h12;
	localparam logic [5:0] IDX_TX_GO = 6'h13;
	localparam logic [5:0] IDX_COLL = 6'h14;

	// Setup register fields
	localparam int SC_NOCRC = 0;
	localparam int SC_LOOP_LO = 1;
	localparam int SC_LOOP_HI = 2;
	localparam int SC_ATD = 3;
	localparam int SC_LOW_PRIORITY_BACKOFF_EN = 4;
	localparam logic [7:0] SETUP_RST = 8'h00;
	localparam logic [7:0] SETUP_MASK = 8'h1F;

	// Status register fields
	localparam int ST_OK = 0;
	localparam int ST_COL = 2;
	localparam int ST_GAVE_UP = 3;
	localparam int ST_CRS = 4;
	localparam int ST_FU = 5;
	localparam int ST_CDH = 6;
	localparam int ST_LATE = 7;

	// Interrupt bits
	localparam int IRQ_W = 4;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ABORT = 1;
	localparam int IRQ_HB = 2;
	localparam int IRQ_LATE = 3;

	// Collision handling
	localparam int COLL_W = 5;
	localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
	localparam logic [4:0] LOW_PRIORITY_BACKOFF_EN_COLLS = 5'h03;
	localparam logic [3:0] EXP_BASE = 4'h3;
	localparam logic [3:0] EXP_MAX = 4'hA;
	localparam logic [5:0] HASH_OFF = 6'h3E; // Bit 62
	localparam logic [5:0] HASH_ON = 6'h3F; // Bit 63
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;

	typedef enum logic [1:0] {
		LOOP_NORMAL = 2'b00,
		LOOP_CORE = 2'b01,
		LOOP_CODEC = 2'b10,
		LOOP_EXT = 2'b11
	} loop_mode_e;

	typedef enum logic [1:0] {
		TS_IDLE = 2'b00,
		TS_SEND = 2'b01,
		TS_HBEAT = 2'b10
	} tx_state_e;

endpackage

// file: core/mac_tx_config_status.sv
// Transmit setup and transmit event status of a 10 Mbit/s CSMA/CD MAC.
// Assumes the transmit engine reports attempts, collisions, carrier,
// FIFO underrun, frame end and heartbeat as signals synchronous to MCLK_I.
//
// Overview of operation
// [R1] Setup register write-only, loop bits reset zero
// [R2] Bit 0 low appends CRC, high omits
// [R3] CRC inhibit honoured in every loopback mode
// [R4] Loop field picks mode, codec loop drives output
// [R5] Host clears data setup D3 before loopback
// [R6] Hash 62 disables, 63 re-enables transmitter
// [R7] Clearing remote disable bit re-enables transmitter
// [R8] Offset backoff 0..2^min(3+n,10) first three
// [R9] n counts collisions of current frame from one
// [R10] Status read-only, cleared on next start
// [R11] Status bits zero unless their event occurs
// [R12] Host reads status after each transmission
// [R13] Done-ok set when no abort, no underrun
// [R14] Collided bit set on any collision
// [R15] Abort at sixteenth attempt colliding
// [R16] Carrier loss flagged, transmission continues
// [R17] FIFO underrun flagged and frame aborted
// [R18] Missing heartbeat within 6.4 us flagged
// [R19] Late collision flagged, frame still rescheduled
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module mac_tx_config_status
	import mac_tx_pkg::*;
(
	input wire logic MCLK_I,
	input wire logic SRST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [mac_tx_pkg::ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic TX_ATTEMPT_I,
	input wire logic COLL_I,
	input wire logic CARRIER_I,
	input wire logic FIFO_DRY_I,
	input wire logic FRAME_END_I,
	input wire logic HEARTBEAT_I,
	input wire logic MCAST_HIT_I,
	input wire logic [5:0] MCAST_IDX_I,
	output logic TX_GO_O,
	output logic TX_ENABLE_O,
	output logic CRC_APPEND_O,
	output logic [1:0] LOOP_MODE_O,
	output logic CODEC_LOOP_O,
	output logic RETRY_O,
	output logic [9:0] BACKOFF_SLOTS_O,
	output logic ABORT_O,
	output logic IRQ_O
);
	import mac_tx_pkg::*;

	logic [7:0] setup_q; // Write-only transmit setup
	logic [7:0] status_q; // Transmit event status
	tx_state_e state_q; // Transmit sequencing state
	logic [COLL_W-1:0] coll_q; // Collisions of current frame
	logic [TMR_W-1:0] tmr_q; // Slot or heartbeat timer
	logic on_wire_q; // An attempt is being sent
	logic remote_off_q; // Disabled by a remote station
	logic [15:0] lfsr_q; // Backoff randomness
	logic [IRQ_W-1:0] irq_stat_q; // Sticky interrupt status
	logic [IRQ_W-1:0] irq_en_q; // Interrupt enables
	logic retry_q; // Reschedule pulse
	logic abort_q; // Abort pulse
	logic go_q; // Start pulse
	logic [9:0] backoff_q; // Backoff slot count

	// Bus decode
	logic wr_en; // Write takes effect this edge
	logic rd_en; // Read answered this edge
	logic [5:0] idx; // Register index
	logic mapped; // Address hits a register
	logic aligned; // Word-aligned access
	logic start; // Host starts a transmission
	logic [IRQ_W-1:0] irq_set; // Interrupt events this cycle
	logic [IRQ_W-1:0] irq_clr; // Write-one-to-clear mask
	logic coll_ev; // Collision during an attempt
	logic late; // Collision after one slot
	logic give_up; // Attempt count exhausted
	logic [COLL_W-1:0] coll_nx; // Collision count incl. this one
	logic [3:0] bexp; // Backoff exponent
	logic [9:0] bmask; // Backoff range mask

	assign idx = PADDR_I[7:2];
	assign aligned = (PADDR_I[1:0] == 2'b00);
	assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
	assign rd_en = PSEL_I && PENABLE_I && !PWRITE_I;
	// Zero wait states: every access completes in its access phase
	assign PREADY_O = 1'b1;

	// Address map check
	always_comb
	begin
		case (idx)
			IDX_STATUS, IDX_SETUP, IDX_IRQ_STAT, IDX_IRQ_EN,
			IDX_IRQ_CLR, IDX_TX_GO, IDX_COLL: mapped = aligned;
			default: mapped = 1'b0;
		endcase
	end

	// Unmapped or misaligned accesses answer with an error
	assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

	// A start is refused while busy or remotely disabled
	assign start = wr_en && mapped && (idx == IDX_TX_GO)
		&& PWDATA_I[0] && (state_q == TS_IDLE) && !remote_off_q;

	// Setup register: write-only, all option bits cleared at reset
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
			setup_q <= SETUP_RST; // R1
		else if (wr_en && mapped && idx == IDX_SETUP)
			setup_q <= PWDATA_I[7:0] & SETUP_MASK; // R1
	end

	// CRC control is independent of the loop field, so CRC logic can be
	// exercised in any loopback mode
	assign CRC_APPEND_O = !setup_q[SC_NOCRC]; // R2 R3
	assign LOOP_MODE_O = setup_q[SC_LOOP_HI:SC_LOOP_LO]; // R4
	// Only the codec loop raises the loop output
	assign CODEC_LOOP_O = (loop_mode_e'(LOOP_MODE_O) == LOOP_CODEC); // R4

	// Remote transmit disable by special multicast hashes
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
			remote_off_q <= 1'b0;
		else if (!setup_q[SC_ATD])
			remote_off_q <= 1'b0; // R7
		else if (MCAST_HIT_I && MCAST_IDX_I == HASH_OFF)
			remote_off_q <= 1'b1; // R6
		else if (MCAST_HIT_I && MCAST_IDX_I == HASH_ON)
			remote_off_q <= 1'b0; // R6
	end

	assign TX_ENABLE_O = !remote_off_q;

	// Collision bookkeeping
	assign coll_ev = COLL_I && on_wire_q && (state_q == TS_SEND);
	assign coll_nx = coll_q + 5'h01; // R9
	// Count reaches sixteen when the sixteenth attempt collides
	assign give_up = coll_ev && (coll_nx == MAX_ATTEMPTS); // R15
	assign late = coll_ev && (tmr_q >= TMR_W'(SLOT_CYC)); // R19

	// Backoff exponent: raised by three for the first three collisions
	always_comb
	begin
		if (setup_q[SC_LOW_PRIORITY_BACKOFF_EN] && coll_nx <= LOW_PRIORITY_BACKOFF_EN_COLLS)
			bexp = EXP_BASE + coll_nx[3:0]; // R8
		else if (coll_nx >= 5'(EXP_MAX))
			bexp = EXP_MAX;
		else
			bexp = coll_nx[3:0];
		bmask = 10'((11'h001 << bexp) - 11'h001); // R8
	end

	// Free-running LFSR; randomness only, so its state never matters
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
			lfsr_q <= LFSR_SEED;
		else
			lfsr_q <= {lfsr_q[14:0], ^(lfsr_q & LFSR_TAPS)};
	end

	// Transmit sequencing
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
			state_q <= TS_IDLE;
		else
		begin
			case (state_q)
				TS_IDLE:
					if (start)
						state_q <= TS_SEND;
				TS_SEND:
					if (FIFO_DRY_I || give_up)
						state_q <= TS_IDLE; // R15 R17
					else if (FRAME_END_I && on_wire_q)
						state_q <= TS_HBEAT;
				TS_HBEAT:
					if (HEARTBEAT_I || tmr_q == TMR_W'(HB_CYC - 1))
						state_q <= TS_IDLE; // R18
				default:
					state_q <= TS_IDLE;
			endcase
		end
	end

	// Slot timer per attempt, then heartbeat window timer
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
			tmr_q <= '0;
		else if (start || TX_ATTEMPT_I || state_q == TS_IDLE)
			tmr_q <= '0;
		else if (state_q == TS_SEND && FRAME_END_I)
			tmr_q <= '0; // Heartbeat window opens
		else if (tmr_q != '1)
			tmr_q <= tmr_q + 12'h001; // Saturates, never wraps
	end

	// An attempt is on the wire from its start to collision or end
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
			on_wire_q <= 1'b0;
		else if (state_q != TS_SEND || coll_ev || FRAME_END_I)
			on_wire_q <= 1'b0;
		else if (TX_ATTEMPT_I)
			on_wire_q <= 1'b1;
	end

	// Collision count of the current frame
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
			coll_q <= '0;
		else if (start)
			coll_q <= '0; // R9
		else if (coll_ev)
			coll_q <= coll_nx; // R9
	end

	// Reschedule: late collisions are retried like ordinary ones
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
		begin
			retry_q <= 1'b0;
			abort_q <= 1'b0;
			go_q <= 1'b0;
			backoff_q <= '0;
		end
		else
		begin
			go_q <= start;
			retry_q <= coll_ev && !give_up && !FIFO_DRY_I; // R19
			abort_q <= (state_q == TS_SEND) && (give_up || FIFO_DRY_I);
			if (coll_ev)
				backoff_q <= lfsr_q[9:0] & bmask; // R8
		end
	end

	assign TX_GO_O = go_q;
	assign RETRY_O = retry_q;
	assign ABORT_O = abort_q;
	assign BACKOFF_SLOTS_O = backoff_q;

	// Event status: cleared at start, bits set only by their event
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
			status_q <= '0;
		else if (start)
			status_q <= '0; // R10
		else
		begin
			if (coll_ev)
				status_q[ST_COL] <= 1'b1; // R14
			if (give_up)
				status_q[ST_GAVE_UP] <= 1'b1; // R15
			if (on_wire_q && state_q == TS_SEND && !CARRIER_I)
				status_q[ST_CRS] <= 1'b1; // R16
			if (state_q == TS_SEND && FIFO_DRY_I)
				status_q[ST_FU] <= 1'b1; // R17
			if (late)
				status_q[ST_LATE] <= 1'b1; // R19
			// Abort and underrun leave the state machine first, so an
			// end seen here belongs to a clean frame
			if (state_q == TS_SEND && FRAME_END_I && on_wire_q
				&& !FIFO_DRY_I && !give_up
				&& !status_q[ST_GAVE_UP] && !status_q[ST_FU])
				status_q[ST_OK] <= 1'b1; // R13
			if (state_q == TS_HBEAT && !HEARTBEAT_I
				&& tmr_q == TMR_W'(HB_CYC - 1))
				status_q[ST_CDH] <= 1'b1; // R18 R11
		end
	end

	// Interrupt events and sticky status; set wins over clear
	assign irq_set[IRQ_DONE] = state_q == TS_SEND && FRAME_END_I
		&& on_wire_q && !FIFO_DRY_I && !give_up;
	assign irq_set[IRQ_ABORT] = (state_q == TS_SEND)
		&& (give_up || FIFO_DRY_I);
	assign irq_set[IRQ_HB] = state_q == TS_HBEAT && !HEARTBEAT_I
		&& tmr_q == TMR_W'(HB_CYC - 1);
	assign irq_set[IRQ_LATE] = late;
	assign irq_clr = (wr_en && mapped && idx == IDX_IRQ_CLR)
		? PWDATA_I[IRQ_W-1:0] : '0;

	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
			irq_stat_q <= '0;
		else
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
	end

	// Interrupt enable register
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
			irq_en_q <= '0;
		else if (wr_en && mapped && idx == IDX_IRQ_EN)
			irq_en_q <= PWDATA_I[IRQ_W-1:0];
	end

	// Level interrupt while any enabled event is pending
	assign IRQ_O = |(irq_stat_q & irq_en_q);

	// Read data register; write-only locations read as zero
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
			PRDATA_O <= '0;
		else if (PSEL_I && !PENABLE_I && !PWRITE_I)
		begin
			case (idx)
				IDX_STATUS: PRDATA_O <= {24'h000000, status_q}; // R10
				IDX_IRQ_STAT: PRDATA_O <= {28'h0000000, irq_stat_q};
				IDX_IRQ_EN: PRDATA_O <= {28'h0000000, irq_en_q};
				IDX_COLL: PRDATA_O <= {27'h0000000, coll_q}; // R14
				default: PRDATA_O <= '0; // R1
			endcase
		end
	end

	// Checks

	property p_loop_out;
		@(posedge MCLK_I) disable iff (SRST_I)
		CODEC_LOOP_O == (setup_q[SC_LOOP_HI] && !setup_q[SC_LOOP_LO]);
	endproperty
	a_loop_out: assert property (p_loop_out) // R4
		else $error("Codec loop output disagrees with mode");

	property p_reset_loop;
		@(posedge MCLK_I) SRST_I |=> LOOP_MODE_O == 2'b00;
	endproperty
	a_reset_loop: assert property (p_reset_loop) // R1
		else $error("Loop field not zero after reset");

	property p_crc_write;
		@(posedge MCLK_I) disable iff (SRST_I)
		(wr_en && mapped && idx == IDX_SETUP)
		|=> CRC_APPEND_O == !$past(PWDATA_I[0]);
	endproperty
	a_crc_write: assert property (p_crc_write) // R2
		else $error("CRC append does not follow written bit");

	property p_remote_off;
		@(posedge MCLK_I) disable iff (SRST_I)
		(setup_q[SC_ATD] && MCAST_HIT_I && MCAST_IDX_I == HASH_OFF)
		|=> !TX_ENABLE_O;
	endproperty
	a_remote_off: assert property (p_remote_off) // R6
		else $error("Hash 62 did not disable transmitter");

	property p_atd_clear;
		@(posedge MCLK_I) disable iff (SRST_I)
		!setup_q[SC_ATD] |=> TX_ENABLE_O;
	endproperty
	a_atd_clear: assert property (p_atd_clear) // R7
		else $error("Transmitter stays off with disable bit clear");

	property p_start_clear;
		@(posedge MCLK_I) disable iff (SRST_I)
		start |=> status_q == 8'h00 && state_q == TS_SEND;
	endproperty
	a_start_clear: assert property (p_start_clear) // R10
		else $error("Status not cleared at start");

	property p_collided;
		@(posedge MCLK_I) disable iff (SRST_I)
		coll_ev |=> status_q[ST_COL] && coll_q == $past(coll_q) + 5'h01;
	endproperty
	a_collided: assert property (p_collided) // R14
		else $error("Collision not recorded");

	property p_give_up;
		@(posedge MCLK_I) disable iff (SRST_I)
		(coll_ev && coll_q == 5'h0F)
		|=> status_q[ST_GAVE_UP] && ABORT_O && state_q == TS_IDLE;
	endproperty
	a_give_up: assert property (p_give_up) // R15
		else $error("No abort at sixteenth attempt");

	property p_underrun;
		@(posedge MCLK_I) disable iff (SRST_I)
		(state_q == TS_SEND && FIFO_DRY_I)
		|=> status_q[ST_FU] && ABORT_O ##1 !status_q[ST_OK];
	endproperty
	a_underrun: assert property (p_underrun) // R17 R13
		else $error("Underrun not flagged or not aborted");

	property p_heartbeat;
		@(posedge MCLK_I) disable iff (SRST_I)
		(state_q == TS_SEND && FRAME_END_I && on_wire_q && !FIFO_DRY_I
			&& !give_up && !HEARTBEAT_I)
		##1 (!HEARTBEAT_I && state_q == TS_HBEAT) [*8]
		|-> ##[1:320] (state_q == TS_IDLE || HEARTBEAT_I);
	endproperty
	a_heartbeat: assert property (p_heartbeat) // R18
		else $error("Heartbeat window did not close in time");

	property p_backoff;
		@(posedge MCLK_I) disable iff (SRST_I)
		(coll_ev && setup_q[SC_LOW_PRIORITY_BACKOFF_EN] && coll_q == 5'h00)
		|=> BACKOFF_SLOTS_O < 10'h010;
	endproperty
	a_backoff: assert property (p_backoff) // R8
		else $error("Offset backoff out of range at first collision");

	property p_late;
		@(posedge MCLK_I) disable iff (SRST_I)
		(coll_ev && !give_up && !FIFO_DRY_I && tmr_q >= TMR_W'(SLOT_CYC))
		|=> status_q[ST_LATE] && RETRY_O;
	endproperty
	a_late: assert property (p_late) // R19
		else $error("Late collision not flagged or not retried");

	property p_carrier;
		@(posedge MCLK_I) disable iff (SRST_I)
		(on_wire_q && state_q == TS_SEND && !CARRIER_I && !FIFO_DRY_I
			&& !give_up)
		|=> status_q[ST_CRS] && state_q != TS_IDLE;
	endproperty
	a_carrier: assert property (p_carrier) // R16
		else $error("Carrier loss mishandled");

endmodule

// file: tb/xcvr_model.sv
// Behavioural transmit engine and transceiver on the media side.
// Assumes the caller starts a frame right after the block raises TX_GO_O.
`timescale 1ns/1ps
module xcvr_model (
	input wire logic clk_i,
	output logic attempt_o,
	output logic coll_o,
	output logic carrier_o,
	output logic dry_o,
	output logic end_o,
	output logic hb_o
);
	// Every strobe idles low; carrier is absent outside frames, except that it stays high after a sixteen-collision frame
	initial
	begin
		attempt_o = 1'b0;
		coll_o = 1'b0;
		carrier_o = 1'b0;
		dry_o = 1'b0;
		end_o = 1'b0;
		hb_o = 1'b0;
	end

	// One frame: nc collisions, carrier drop, underrun, late hit, heartbeat
	task frame(input int nc, input bit dr, input bit dy, input bit lt,
		input bit hb);
		int i;
		for (i = 0; i <= nc && i < 16; i++)
		begin
			@(posedge clk_i);
			attempt_o <= 1'b1;
			carrier_o <= 1'b1;
			@(posedge clk_i);
			attempt_o <= 1'b0;
			carrier_o <= !dr;
			@(posedge clk_i);
			carrier_o <= 1'b1;
			if (dy)
			begin
				dry_o <= 1'b1;
				@(posedge clk_i);
				dry_o <= 1'b0;
				carrier_o <= 1'b0;
				return;
			end
			// A late hit has to come after one full slot time
			if (lt && i == 0)
				repeat (2600) @(posedge clk_i);
			if (i < nc)
			begin
				coll_o <= 1'b1;
				@(posedge clk_i);
				coll_o <= 1'b0;
				repeat (3) @(posedge clk_i);
			end
		end
		// The sixteenth collision ends the frame with no end strobe
		if (nc < 16)
		begin
			end_o <= 1'b1;
			@(posedge clk_i);
			end_o <= 1'b0;
			carrier_o <= 1'b0;
			repeat (10) @(posedge clk_i);
			hb_o <= hb;
			@(posedge clk_i);
			hb_o <= 1'b0;
		end
	endtask
endmodule

// file: tb/mac_tx_config_status_test.sv
// Self-checking bench for the transmit setup and status block.
// Assumes the media side model and an APB master built from tasks here.
`timescale 1ns/1ps
module mac_tx_config_status_test;
	import mac_tx_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic att, col, carrier_lost_flag, dry, fend, hbt;
	logic hit = 1'b0;
	logic [5:0] hidx = 6'h00;
	logic go, txen, crc, cdl, retry, abrt, irq;
	logic [1:0] loop;
	logic [9:0] slots;
	logic [31:0] rd;
	logic err;
	logic low_priority_backoff_en = 1'b0;
	int num_errors = 0;
	int n_checks = 0;
	int n_retry = 0;
	int n_abort = 0;
	int bk;

	// 50 MHz system clock
	always #10 mclk = ~mclk;

	mac_tx_config_status u_mac_tx_config_status (.MCLK_I(mclk),
		.SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.TX_ATTEMPT_I(att), .COLL_I(col), .CARRIER_I(carrier_lost_flag),
		.FIFO_DRY_I(dry), .FRAME_END_I(fend), .HEARTBEAT_I(hbt),
		.MCAST_HIT_I(hit), .MCAST_IDX_I(hidx), .TX_GO_O(go),
		.TX_ENABLE_O(txen), .CRC_APPEND_O(crc), .LOOP_MODE_O(loop),
		.CODEC_LOOP_O(cdl), .RETRY_O(retry), .BACKOFF_SLOTS_O(slots),
		.ABORT_O(abrt), .IRQ_O(irq));

	xcvr_model u_xcvr_model (.clk_i(mclk), .attempt_o(att),
		.coll_o(col), .carrier_o(carrier_lost_flag), .dry_o(dry), .end_o(fend),
		.hb_o(hbt));

	// Verdict; the only place the run ends
	task close_out();
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// A hang counts as a mismatch
	task hang();
		num_errors++;
		close_out();
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge mclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
			hang();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Write, then let the stored value reach the outputs
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		@(posedge mclk);
		#1;
	endtask

	// Backoff range: low-priority option widens the first three draws
	always @(posedge mclk)
	begin
		if (go === 1'b1)
			n_retry = 0;
		if (abrt === 1'b1)
			n_abort++;
		if (retry === 1'b1)
		begin
			n_retry++;
			bk = (low_priority_backoff_en && n_retry <= 3) ? 3 + n_retry : n_retry;
			bk = (bk > 10) ? 10 : bk;
			chk(32'(slots) >> bk, 32'h0);
		end
	end

	// Start a transmission and wait a bounded time for the go strobe
	task start();
		int i;
		apb(1'b1, 8'h4C, 32'h1);
		for (i = 0; i < 4; i++)
		begin
			#1;
			if (go === 1'b1)
				break;
			@(posedge mclk);
		end
		if (i == 4)
			hang();
	endtask

	// Whole frame, then the host reads status after the heartbeat window
	task tx(input int nc, input bit dr, input bit dy, input bit lt,
		input bit hb, input logic [7:0] m, input logic [7:0] e);
		start();
		u_xcvr_model.frame(nc, dr, dy, lt, hb);
		repeat (340) @(posedge mclk);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd & m, 32'(e));
	endtask

	// Reset values, write-only setup, refused address
	task t_reset();
		#1;
		chk({loop, cdl, crc, txen}, 5'b00011);
		apb(1'b0, 8'h34, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'hFC, 32'h0);
		// Error flag and data checked apart; a packed pair would lose bit 32
		chk(32'(err), 32'h1);
		chk(rd, 32'h0);
	endtask

	// Every loop mode with CRC both on and off; the data setup bit D3 lives
	// outside this block and the host is taken to clear it first
	task t_setup();
		int m;
		int c;
		for (m = 0; m < 4; m++)
			for (c = 0; c < 2; c++)
			begin
				wr(8'h34, 32'(m * 2 + c));
				chk(loop, 32'(m));
				chk(cdl, 32'(m == 2));
				chk(crc, 32'(c == 0));
			end
		wr(8'h34, 32'h0);
	endtask

	// Remote disable by multicast hash bits and by clearing the option
	task mcast(input logic [5:0] ix);
		@(posedge mclk);
		hit <= 1'b1;
		hidx <= ix;
		@(posedge mclk);
		hit <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	task t_remote();
		wr(8'h34, 32'h08);
		mcast(6'd62);
		chk(txen, 32'h0);
		mcast(6'd63);
		chk(txen, 32'h1);
		mcast(6'd62);
		wr(8'h34, 32'h0);
		chk(txen, 32'h1);
		mcast(6'd62);
		chk(txen, 32'h1);
	endtask

	// Clean frame drives the interrupt; clear and mask it
	task t_irq();
		wr(8'h44, 32'hF);
		tx(0, 0, 0, 0, 1, 8'hFF, 8'h01);
		chk(irq, 32'h1);
		wr(8'h48, 32'h1);
		chk(irq, 32'h0);
		wr(8'h44, 32'h0);
		tx(0, 0, 0, 0, 1, 8'hFF, 8'h01);
		chk(irq, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h1);
	endtask

	// Old status is wiped when the next transmission starts
	task t_clear();
		start();
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		u_xcvr_model.frame(0, 0, 0, 0, 1);
		repeat (40) @(posedge mclk);
	endtask

	// Watchdog on the whole run
	initial
	begin
		// 50,000 cycles, well above the longest scenario chain
		#1000000;
		hang();
	end

	initial
	begin
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		t_reset();
		t_setup();
		t_remote();
		t_irq();
		tx(2, 1, 0, 0, 1, 8'hFF, 8'h15);
		apb(1'b0, 8'h50, 32'h0);
		chk(rd, 32'h2);
		t_clear();
		wr(8'h34, 32'h10);
		low_priority_backoff_en = 1'b1;
		tx(4, 0, 0, 0, 1, 8'hFF, 8'h05);
		chk(n_retry, 32'h4);
		wr(8'h34, 32'h0);
		low_priority_backoff_en = 1'b0;
		tx(16, 0, 0, 0, 0, 8'h0D, 8'h0C);
		chk(n_abort, 32'h1);
		tx(0, 0, 1, 0, 0, 8'h21, 8'h20);
		chk(n_abort, 32'h2);
		tx(0, 0, 0, 0, 0, 8'hFF, 8'h41);
		tx(1, 0, 0, 1, 1, 8'hFF, 8'h85);
		chk(n_retry, 32'h1);
		close_out();
	end
endmodule
